// ---- logic/updown_capture_timer.sv ----
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module updown_capture_timer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic twelve_clk_mode,
   input wire logic count_pin,
   input wire logic trigger_input,
   input wire logic t1_overflow,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic rx_baud_tick,
   output logic tx_baud_tick
);
   logic [7:0] ctrl_q, ctrl_d;
   logic down_count_enable_q;
   logic [15:0] cnt_q, cnt_d, rld_q, rld_d;
   logic [1:0] mask_q;
   logic [1:0] cnt_sync_q, trg_sync_q, mode_sync_q;
   logic cnt_last_q, trg_last_q;
   logic [3:0] div_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q, rx_q, tx_q;
   updown_timer_pkg::mode_t mode;

   wire wr = psel && penable && pwrite && clk_en;
   wire rd = psel && penable && !pwrite && clk_en;
   wire hit_ctrl = paddr == updown_timer_pkg::CTRL_ADDR;
   wire hit_mode = paddr == updown_timer_pkg::MODE_ADDR;
   wire hit_cnt = paddr == updown_timer_pkg::CNT_ADDR;
   wire hit_rld = paddr == updown_timer_pkg::RLD_ADDR;
   wire hit_mask = paddr == updown_timer_pkg::IRQ_MASK_ADDR;
   wire mapped = hit_ctrl | hit_mode | hit_cnt | hit_rld | hit_mask;

   wire run = ctrl_q[updown_timer_pkg::RUN_BIT];
   wire baud_sel = ctrl_q[updown_timer_pkg::RXSEL_BIT] |
      ctrl_q[updown_timer_pkg::TXSEL_BIT];
   wire exen = ctrl_q[updown_timer_pkg::EXEN_BIT];
   wire twelve = mode_sync_q[1];
   // Mode decode
   assign mode = !run ? updown_timer_pkg::MODE_OFF :
      baud_sel ? updown_timer_pkg::MODE_BAUD :
      ctrl_q[updown_timer_pkg::CAPT_BIT] ? updown_timer_pkg::MODE_CAPT :
      updown_timer_pkg::MODE_RELOAD;

   // Internal tick: machine cycle of 6 or 12 clocks
   wire div_end = twelve ? (div_q == updown_timer_pkg::DIV12) :
      (div_q == {1'b0, updown_timer_pkg::DIV6});
   wire pin_fall = cnt_last_q && !cnt_sync_q[1];
   wire tick = ctrl_q[updown_timer_pkg::SRC_BIT] ? pin_fall : div_end;
   wire trg_fall = trg_last_q && !trg_sync_q[1];
   wire trg_lvl = trg_sync_q[1];
   wire ext_ev = exen && trg_fall;
   wire down_count_enable_act = down_count_enable_q &&
      mode == updown_timer_pkg::MODE_RELOAD;
   wire counting = tick && mode != updown_timer_pkg::MODE_OFF;
   wire go_down = down_count_enable_act && !trg_lvl;
   wire top = cnt_q == updown_timer_pkg::CNT_MAX;
   wire ovf = counting && !go_down && top;
   wire unf = counting && go_down && cnt_q == rld_q;
   // Flag set only outside baud mode
   wire ovf_set = (ovf || unf) && mode != updown_timer_pkg::MODE_BAUD;
   wire ext_set = ext_ev && !down_count_enable_act;
   wire ext_tog = down_count_enable_act && (ovf || unf);
   wire baud_roll = ovf && mode == updown_timer_pkg::MODE_BAUD;

   always_comb begin
      cnt_d = cnt_q;
      if (counting) begin
         if (go_down)
            cnt_d = unf ? updown_timer_pkg::CNT_MAX :
               cnt_q - updown_timer_pkg::CNT_ONE;
         else if (ovf && mode != updown_timer_pkg::MODE_CAPT)
            cnt_d = rld_q;
         else
            cnt_d = cnt_q + updown_timer_pkg::CNT_ONE;
      end
      // Trigger reload only in up-only reload mode
      if (ext_ev && mode == updown_timer_pkg::MODE_RELOAD && !down_count_enable_act)
         cnt_d = rld_q;
      if (wr && hit_cnt)
         cnt_d = pwdata[15:0];
   end

   always_comb begin
      rld_d = rld_q;
      if (wr && hit_rld)
         rld_d = pwdata[15:0];
      // Capture latches both bytes
      if (ext_ev && mode == updown_timer_pkg::MODE_CAPT)
         rld_d = cnt_q;
   end

   // Write-zero clears; hardware set wins
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr && hit_ctrl)
         ctrl_d = pwdata[7:0];
      if (ovf_set)
         ctrl_d[updown_timer_pkg::OVF_BIT] = 1'b1;
      if (ext_set)
         ctrl_d[updown_timer_pkg::EXTF_BIT] = 1'b1;
      if (ext_tog)
         ctrl_d[updown_timer_pkg::EXTF_BIT] =
            !ctrl_q[updown_timer_pkg::EXTF_BIT];
   end

   wire [31:0] rdata = hit_ctrl ? {24'h00_0000, ctrl_q} :
      hit_mode ? {31'h0000_0000, down_count_enable_q} :
      hit_cnt ? {16'h0000, cnt_q} :
      hit_rld ? {16'h0000, rld_q} :
      hit_mask ? {30'h0000_0000, mask_q} : 32'h0000_0000;
   // External flag in up/down mode never interrupts
   wire irq_d = (ctrl_q[updown_timer_pkg::OVF_BIT] && mask_q[0]) ||
      (ctrl_q[updown_timer_pkg::EXTF_BIT] && mask_q[1] &&
      !down_count_enable_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_sync_q <= 2'b11;
         trg_sync_q <= 2'b11;
         mode_sync_q <= 2'b00;
      end else if (clk_en) begin
         cnt_sync_q <= {cnt_sync_q[0], count_pin};
         trg_sync_q <= {trg_sync_q[0], trigger_input};
         mode_sync_q <= {mode_sync_q[0], twelve_clk_mode};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_last_q <= 1'b1;
         trg_last_q <= 1'b1;
         div_q <= 4'h0;
      end else if (clk_en) begin
         cnt_last_q <= cnt_sync_q[1];
         trg_last_q <= trg_sync_q[1];
         div_q <= div_end ? 4'h0 : div_q + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= updown_timer_pkg::CTRL_RESET;
         down_count_enable_q <= 1'b0;
         cnt_q <= 16'h0000;
         rld_q <= 16'h0000;
         mask_q <= 2'b00;
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
         if (wr && hit_mode)
            down_count_enable_q <= pwdata[0];
         cnt_q <= cnt_d;
         rld_q <= rld_d;
         if (wr && hit_mask)
            mask_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
         rx_q <= 1'b0;
         tx_q <= 1'b0;
      end else if (clk_en) begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !mapped;
         if (psel && !penable)
            prdata_q <= rdata;
         irq_q <= irq_d;
         // Baud source select
         rx_q <= ctrl_q[updown_timer_pkg::RXSEL_BIT] ? baud_roll :
            t1_overflow;
         tx_q <= ctrl_q[updown_timer_pkg::TXSEL_BIT] ? baud_roll :
            t1_overflow;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign rx_baud_tick = rx_q;
   assign tx_baud_tick = tx_q;

   a_ovf_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && ovf_set |=> ctrl_q[updown_timer_pkg::OVF_BIT])
      else $error("overflow flag not set");
   a_baud_no_flag: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && mode == updown_timer_pkg::MODE_BAUD &&
      !ctrl_q[updown_timer_pkg::OVF_BIT] && !(wr && hit_ctrl)
      |=> !ctrl_q[updown_timer_pkg::OVF_BIT])
      else $error("baud rollover set flag");
   a_capt_latch: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && ext_ev && mode == updown_timer_pkg::MODE_CAPT
      |=> rld_q == $past(cnt_q))
      else $error("capture missed");
   a_capt_no_reload: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && counting && mode == updown_timer_pkg::MODE_CAPT &&
      !(wr && hit_cnt) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("capture count broke");
   a_up_reload: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && ovf && mode == updown_timer_pkg::MODE_RELOAD &&
      !(wr && hit_cnt) |=> cnt_q == $past(rld_q))
      else $error("reload missed");
   a_down_under: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && unf && !(wr && hit_cnt) |=> cnt_q == 16'hFFFF)
      else $error("underflow load wrong");
   a_ext_toggle: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && ext_tog |=> ctrl_q[updown_timer_pkg::EXTF_BIT] !=
      $past(ctrl_q[updown_timer_pkg::EXTF_BIT]))
      else $error("external flag no toggle");
   a_ext_set_win: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && ext_set |=> ctrl_q[updown_timer_pkg::EXTF_BIT])
      else $error("external set lost");
   a_irq_follow: assert property (@(posedge clk) disable iff (!rst_b)
      clk_en && ctrl_q[updown_timer_pkg::OVF_BIT] && mask_q[0]
      |=> irq)
      else $error("irq not raised");
   c_capture: cover property (@(posedge clk) disable iff (!rst_b)
      ext_ev && mode == updown_timer_pkg::MODE_CAPT);
   c_underflow: cover property (@(posedge clk) disable iff (!rst_b) unf);
   c_baud: cover property (@(posedge clk) disable iff (!rst_b) baud_roll);
endmodule
`default_nettype wire

// ---- logic/updown_timer_pkg.sv ----
package updown_timer_pkg;
   // APB word addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] MODE_ADDR = 8'h04;
   localparam logic [7:0] CNT_ADDR = 8'h08;
   localparam logic [7:0] RLD_ADDR = 8'h0C;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
   // Control bit positions
   localparam int OVF_BIT = 7;
   localparam int EXTF_BIT = 6;
   localparam int RXSEL_BIT = 5;
   localparam int TXSEL_BIT = 4;
   localparam int EXEN_BIT = 3;
   localparam int RUN_BIT = 2;
   localparam int SRC_BIT = 1;
   localparam int CAPT_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [2:0] DIV6 = 3'h5;
   localparam logic [3:0] DIV12 = 4'hB;
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_BAUD = 2'b01,
      MODE_CAPT = 2'b10,
      MODE_RELOAD = 2'b11
   } mode_t;
endpackage

// ---- tb/ext_pins.sv ----
`timescale 1ns/10ps
`default_nettype none
module ext_pins (
   input wire logic clk,
   output logic count_pin,
   output logic trigger_input
);
   initial begin
      count_pin = 1'b1;
      trigger_input = 1'b1;
   end
   // Levels held 4 clocks, longer than the 2-stage input sync
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk) count_pin <= 1'b0;
         repeat (4) @(posedge clk);
         count_pin <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic trig(input logic v);
      @(posedge clk) trigger_input <= v;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, t1_ovf = 1'b0, pready, pslverr, irq, err;
   logic rx_tick, tx_tick, cnt_pin, trig;
   logic en = 1'b1, twelve = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdv, s = 32'h0000_0016;
   logic [15:0] v;
   int fail_count = 0, total_checks = 0, txn = 0, rxn = 0, n, m;
   always #20 clk = ~clk;
   always @(posedge clk) begin
      txn <= txn + int'(tx_tick === 1'b1);
      rxn <= rxn + int'(rx_tick === 1'b1);
   end
   updown_capture_timer i_updown_capture_timer (.clk(clk),
      .rst_b(rst_b), .clk_en(en), .twelve_clk_mode(twelve),
      .count_pin(cnt_pin), .trigger_input(trig), .t1_overflow(t1_ovf),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .rx_baud_tick(rx_tick),
      .tx_baud_tick(tx_tick));
   ext_pins i_ext_pins (.clk(clk), .count_pin(cnt_pin),
      .trigger_input(trig));
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k == 16) fail_count++;
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic end_sim();
      $display("Checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Whole run is about 750 clocks; watchdog at 20000
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(updown_timer_pkg::CTRL_ADDR);
      chk("ctrl reset", {24'h00_0000, updown_timer_pkg::CTRL_RESET}, rdv);
      rd(updown_timer_pkg::MODE_ADDR);
      chk("mode reset", 32'h0000_0000, rdv);
      rd(8'h20);
      chk("unmapped", 32'h0000_0001, {31'h0, err});
      wr(updown_timer_pkg::RLD_ADDR, 32'h0000_FFF0);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_FFFD);
      wr(updown_timer_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0004);
      repeat (40) @(posedge clk);
      chk("ovf irq", 32'h0000_0001, {31'h0, irq});
      rd(updown_timer_pkg::CTRL_ADDR);
      chk("ovf ctrl", 32'h0000_0084, rdv);
      rd(updown_timer_pkg::CNT_ADDR);
      chk("reload", 32'h0000_0FFF, rdv >> 4);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk("irq clear", 32'h0000_0000, {31'h0, irq});
      n = int'(xs());
      v = {1'b0, n[14:8], 8'h00};
      wr(updown_timer_pkg::CNT_ADDR, {16'h0000, v});
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_000D);
      i_ext_pins.trig(1'b0);
      i_ext_pins.trig(1'b1);
      rd(updown_timer_pkg::RLD_ADDR);
      chk("capture", {24'h00_0000, v[15:8]}, rdv >> 8);
      v = rdv[15:0];
      rd(updown_timer_pkg::CNT_ADDR);
      chk("counting", 32'h0000_0001, {31'h0, rdv[15:0] >= v});
      rd(updown_timer_pkg::CTRL_ADDR);
      chk("capt ctrl", 32'h0000_004D, rdv);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::RLD_ADDR, 32'h0000_2200);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_4000);
      wr(updown_timer_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_000C);
      i_ext_pins.trig(1'b0);
      rd(updown_timer_pkg::CNT_ADDR);
      chk("trig reload", 32'h0000_0022, rdv >> 8);
      chk("ext irq", 32'h0000_0001, {31'h0, irq});
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::MODE_ADDR, 32'h0000_0001);
      wr(updown_timer_pkg::RLD_ADDR, 32'h0000_0100);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_0102);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0004);
      repeat (40) @(posedge clk);
      rd(updown_timer_pkg::CTRL_ADDR);
      chk("underflow", 32'h0000_00C4, rdv);
      chk("no ext irq", 32'h0000_0000, {31'h0, irq});
      rd(updown_timer_pkg::CNT_ADDR);
      chk("load max", 32'h0000_00FF, rdv >> 8);
      i_ext_pins.trig(1'b1);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_FFFE);
      repeat (30) @(posedge clk);
      rd(updown_timer_pkg::CTRL_ADDR);
      chk("up toggle", 32'h0000_0084, rdv);
      rd(updown_timer_pkg::CNT_ADDR);
      chk("up reload", 32'h0000_0001, rdv >> 8);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::MODE_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0006);
      n = int'(xs() % 8) + 1;
      i_ext_pins.pulse(n);
      rd(updown_timer_pkg::CNT_ADDR);
      chk("edges", n, rdv);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::RLD_ADDR, 32'h0000_FFFE);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_FFFE);
      wr(updown_timer_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0014);
      n = txn;
      m = rxn;
      repeat (60) @(posedge clk);
      t1_ovf <= 1'b1;
      @(posedge clk) t1_ovf <= 1'b0;
      repeat (3) @(posedge clk);
      chk("tx ticks", 32'h0000_0001, {31'h0, txn - n >= 4});
      chk("rx ticks", 32'h0000_0001, rxn - m);
      rd(updown_timer_pkg::CTRL_ADDR);
      chk("baud flag", 32'h0000_0014, rdv);
      chk("baud irq", 32'h0000_0000, {31'h0, irq});
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0000);
      wr(updown_timer_pkg::CNT_ADDR, 32'h0000_0000);
      twelve <= 1'b1;
      repeat (4) @(posedge clk);
      wr(updown_timer_pkg::CTRL_ADDR, 32'h0000_0004);
      repeat (60) @(posedge clk);
      // Frozen span must add no ticks
      en <= 1'b0;
      repeat (200) @(posedge clk);
      en <= 1'b1;
      repeat (60) @(posedge clk);
      rd(updown_timer_pkg::CNT_ADDR);
      chk("slow ticks", 32'h0000_0001, {31'h0, rdv >= 32'h0000_0009 &&
         rdv <= 32'h0000_000B});
      end_sim();
   end
endmodule
`default_nettype wire
